//--- core/dtwsl_map.vh
// Purpose: constants shared by the two-wire converter loader
// Assumes: 40 MHz system clock
// Notes: times are kept in their own unit, counts are derived in the module
`ifndef DTWSL_MAP_VH
`define DTWSL_MAP_VH

`define DTWSL_CLK_KHZ        40000
`define DTWSL_CLK_MHZ        40
`define DTWSL_CLR_MS         10
`define DTWSL_SCLK_HALF_NS   100
`define DTWSL_WORD_BITS      12
`define DTWSL_CNT_W          4
`define DTWSL_CNT_LAST_BIT   4'hB
`define DTWSL_CNT_LOAD       4'hC
`define DTWSL_CNT_PRESET     4'h0
`define DTWSL_CNT_STEP       4'h1

`define DTWSL_ST_W           2
`define DTWSL_ST_IDLE        2'h0
`define DTWSL_ST_SEL         2'h1
`define DTWSL_ST_RUN         2'h2
`define DTWSL_ST_DONE        2'h3

`endif

//--- core/dtwsl_host.v
// Purpose: host-side two-wire loader for a 12-bit serial converter
// Assumes: words arrive through a small fifo; serial clock made here by a divider
// Notes: clear, counter, strobe and selects are generated in the clk domain
// Notes on behaviour
// - bit counter advances by one on each of the first twelve rising edges of the serial clock line
// - converter clock is the inverted serial clock, shifting on its rising edge
// - counter reaches 1100 and the load strobe is driven low
// - load strobe also presets the counter so the thirteenth rise does not shift
// - clocking stops after the thirteenth pulse; converter clock idles high, count zero
// - further words repeat the same thirteen-pulse sequence, with release, fetch and select ticks between them
// - power-on clear holds converter and counter clear for about 10 ms
// - in the single-converter arrangement chip select is high in reset and stays low from the first clock after it
// - all converters see the same bits; only the selected one loads
// - the select decoder is enabled only after its address has settled
// - serial clock is returned low one tick before chip select is released
`timescale 1ns/1ps
`include "dtwsl_map.vh"

module dtwsl_fifo #(
    parameter W     = 12,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire         in_valid,
    output reg          in_ready,
    input  wire [W-1:0] in_data,
    output reg          out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    // word storage and pointers
    reg [W-1:0] mem [0:DEPTH-1];

    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0]   count;
    wire         push;
    wire         pop;
    reg [AW:0]   next_count;

    // handshake qualifiers
    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    // pointer step with wrap at depth
    function [AW-1:0] ptr_inc;
        input [AW-1:0] p;
        begin
            if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1})
                ptr_inc = {AW{1'b0}};
            else
                ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
        end
    endfunction

    // fill level after this cycle

    always @* begin
        next_count = count;
        if (push && !pop)
            next_count = count + {{AW{1'b0}}, 1'b1};
        else if (pop && !push)
            next_count = count - {{AW{1'b0}}, 1'b1};
    end

    // storage write, no reset needed

    always @(posedge clk) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // pointers, level and registered flags

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push)
                wr_ptr <= ptr_inc(wr_ptr);
            if (pop)
                rd_ptr <= ptr_inc(rd_ptr);
            count     <= next_count;
            in_ready  <= (next_count != DEPTH[AW:0]);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule // dtwsl_fifo

module dtwsl_host #(
    parameter NCONV      = 2,
    parameter SELW       = 1,
    parameter MULTI      = 1,
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW    = 2,
    parameter CLR_CYCLES = `DTWSL_CLR_MS * `DTWSL_CLK_KHZ,
    parameter CLRW       = 20
) (
    input  wire                          clk,
    input  wire                          sys_rst,
    input  wire                          word_valid,
    output wire                          word_ready,
    input  wire [`DTWSL_WORD_BITS-1:0]   word_data,
    input  wire [SELW-1:0]               word_sel,
    input  wire                          clear_req,
    output reg                           serial_clk,
    output reg                           serial_data_in,
    output reg                           conv_clk,
    output reg                           load_strobe_n,
    output reg                           clear_n,
    output reg  [NCONV-1:0]              chip_select_n,
    output reg                           limit_converter_select,
    output reg  [`DTWSL_CNT_W-1:0]       bit_count,
    output reg                           busy
);
    localparam HALF_CYC = (`DTWSL_SCLK_HALF_NS * `DTWSL_CLK_MHZ + 999) / 1000;
    localparam HALFW    = 8;
    localparam FW       = `DTWSL_WORD_BITS + SELW;

    wire                        f_valid;
    reg                         f_pop;
    wire [FW-1:0]               f_data;
    reg  [`DTWSL_ST_W-1:0]      state;
    reg  [HALFW-1:0]            div_cnt;
    reg                         tick;
    reg  [CLRW-1:0]             clr_cnt;
    reg  [`DTWSL_WORD_BITS-1:0] shreg;
    reg  [SELW-1:0]             sel;
    wire [`DTWSL_CNT_W-1:0]     next_count;

    // index to active-low one-hot select
    function [NCONV-1:0] sel_decode_n;
        input [SELW-1:0] s;
        integer i;
        begin
            sel_decode_n = {NCONV{1'b1}};
            for (i = 0; i < NCONV; i = i + 1)
                if (s == i[SELW-1:0])
                    sel_decode_n[i] = 1'b0;
        end
    endfunction

    // word and index wait here until the link is free

    dtwsl_fifo #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (word_valid),
        .in_ready  (word_ready),
        .in_data   ({word_sel, word_data}),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    // bit counter step

    assign next_count = bit_count + `DTWSL_CNT_STEP;


    // power-on and requested clear
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clr_cnt <= {CLRW{1'b0}};
            clear_n <= 1'b0;
        end else if (clear_req) begin
            clr_cnt <= {CLRW{1'b0}};
            clear_n <= 1'b0;
        end else if (clr_cnt != CLR_CYCLES[CLRW-1:0] - {{(CLRW-1){1'b0}}, 1'b1}) begin
            clr_cnt <= clr_cnt + {{(CLRW-1){1'b0}}, 1'b1};
            clear_n <= 1'b0;
        end else begin
            clear_n <= 1'b1;
        end
    end

    // half-period enable for the serial clock
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt <= {HALFW{1'b0}};
            tick    <= 1'b0;
        end else if (div_cnt == HALF_CYC[HALFW-1:0] - {{(HALFW-1){1'b0}}, 1'b1}) begin
            div_cnt <= {HALFW{1'b0}};
            tick    <= 1'b1;
        end else begin
            div_cnt <= div_cnt + {{(HALFW-1){1'b0}}, 1'b1};
            tick    <= 1'b0;
        end
    end

    // sequencer: select, thirteen pulses, strobe, release
    // a clear holds it idle with the counter at zero

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state                  <= `DTWSL_ST_IDLE;
            f_pop                  <= 1'b0;
            serial_clk             <= 1'b0;
            conv_clk               <= 1'b1;
            serial_data_in         <= 1'b0;
            load_strobe_n          <= 1'b1;
            bit_count              <= `DTWSL_CNT_PRESET;
            shreg                  <= {`DTWSL_WORD_BITS{1'b0}};
            sel                    <= {SELW{1'b0}};
            chip_select_n          <= {NCONV{1'b1}};
            limit_converter_select <= 1'b0;
            busy                   <= 1'b0;
        end else if (!clear_n) begin
            state          <= `DTWSL_ST_IDLE;
            f_pop          <= 1'b0;
            serial_clk     <= 1'b0;
            conv_clk       <= 1'b1;
            load_strobe_n  <= 1'b1;
            bit_count      <= `DTWSL_CNT_PRESET;
            busy           <= 1'b0;
            chip_select_n  <= MULTI ? {NCONV{1'b1}} : {NCONV{1'b0}};
        end else begin
            f_pop <= 1'b0;
            if (MULTI == 0)
                chip_select_n <= {NCONV{1'b0}};
            case (state)

                // wait for a word and a tick
                `DTWSL_ST_IDLE: begin
                    busy <= 1'b0;
                    if (f_valid && !f_pop && tick) begin
                        f_pop                  <= 1'b1;
                        shreg                  <= f_data[`DTWSL_WORD_BITS-1:0];
                        sel                    <= f_data[FW-1:`DTWSL_WORD_BITS];
                        limit_converter_select <= f_data[`DTWSL_WORD_BITS];
                        busy                   <= 1'b1;
                        state                  <= `DTWSL_ST_SEL;
                    end
                end

                // select settles one tick before the first pulse
                `DTWSL_ST_SEL: begin
                    if (tick) begin
                        if (MULTI != 0)
                            chip_select_n <= sel_decode_n(sel);
                        state <= `DTWSL_ST_RUN;
                    end
                end

                // twelve data pulses and the strobe pulse
                `DTWSL_ST_RUN: begin
                    if (tick) begin
                        if (!serial_clk) begin
                            serial_clk <= 1'b1;
                            conv_clk   <= 1'b0;
                            if (!load_strobe_n) begin
                                bit_count     <= `DTWSL_CNT_PRESET;
                                load_strobe_n <= 1'b1;
                                state         <= `DTWSL_ST_DONE;
                            end else begin
                                bit_count      <= next_count;
                                serial_data_in <= shreg[`DTWSL_WORD_BITS-1];
                                shreg          <= {shreg[`DTWSL_WORD_BITS-2:0], 1'b0};
                            end
                        end else begin
                            serial_clk <= 1'b0;
                            conv_clk   <= 1'b1;
                            if (bit_count == `DTWSL_CNT_LOAD)
                                load_strobe_n <= 1'b0;
                        end
                    end
                end

                // last fall, then release the selects
                `DTWSL_ST_DONE: begin
                    if (tick) begin
                        if (serial_clk) begin
                            serial_clk <= 1'b0;
                            conv_clk   <= 1'b1;
                        end else begin
                            if (MULTI != 0)
                                chip_select_n <= {NCONV{1'b1}};
                            state <= `DTWSL_ST_IDLE;
                        end
                    end
                end

                // unused code returns to idle
                default: begin
                    state <= `DTWSL_ST_IDLE;
                end
            endcase
        end
    end
endmodule // dtwsl_host

//--- tb/dtwsl_conv_model.sv
// Purpose: behavioural 12-bit serial converter at the far end
// Assumes: shifts on rising conv_clk while selected
// Notes: value is the output register
`timescale 1ns/1ps
module dtwsl_conv_model (
    input  wire logic        conv_clk,
    input  wire logic        serial_data_in,
    input  wire logic        load_strobe_n,
    input  wire logic        clear_n,
    input  wire logic        select_n,
    output logic      [11:0] value
);
    logic [11:0] shift_reg;
    always @(posedge conv_clk) begin
        if (!select_n) shift_reg <= {shift_reg[10:0], serial_data_in};
    end
    // copy when the strobe ends, so the last bit shifted with the strobe edge is kept
    always @(negedge clear_n or posedge load_strobe_n) begin
        if (!clear_n) value <= 12'h000;
        else if (!select_n) value <= shift_reg;
    end
endmodule // dtwsl_conv_model

//--- tb/dtwsl_host_sva.sv
// Purpose: port checks for the loader
// Assumes: one clock domain
// Notes: bound from the testbench
`timescale 1ns/1ps
module dtwsl_host_sva #(parameter NCONV = 2, parameter SELW = 1) (
    input wire logic             clk,
    input wire logic             sys_rst,
    input wire logic             word_valid,
    input wire logic             word_ready,
    input wire logic [11:0]      word_data,
    input wire logic [SELW-1:0]  word_sel,
    input wire logic             clear_req,
    input wire logic             serial_clk,
    input wire logic             serial_data_in,
    input wire logic             conv_clk,
    input wire logic             load_strobe_n,
    input wire logic             clear_n,
    input wire logic [NCONV-1:0] chip_select_n,
    input wire logic             limit_converter_select,
    input wire logic [3:0]       bit_count,
    input wire logic             busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence strobe_s;
        !load_strobe_n[*3] ##[1:8] load_strobe_n;
    endsequence
    inv_clk_a: assert property (conv_clk != serial_clk) else $error("conv clock");
    cnt_step_a: assert property ($rose(serial_clk) && $past(load_strobe_n) |->
        bit_count == $past(bit_count) + 4'h1) else $error("count step");
    preset_a: assert property ($rose(serial_clk) && !$past(load_strobe_n) |->
        bit_count == 4'h0) else $error("preset");
    strobe_at_a: assert property ($fell(load_strobe_n) |-> bit_count == 4'hC) else $error("strobe");
    strobe_len_a: assert property ($fell(load_strobe_n) |-> strobe_s) else $error("strobe len");
    data_hold_a: assert property (!$rose(serial_clk) |-> $stable(serial_data_in)) else $error("data");
    one_sel_a: assert property ($onehot0(~chip_select_n)) else $error("selects");
    clear_hold_a: assert property (!clear_n && !$past(clear_n) |->
        bit_count == 4'h0 && !serial_clk) else $error("clear hold");
    clk_sel_a: assert property (serial_clk |-> !(&chip_select_n)) else $error("clk sel");
    clr_len_a: assert property ($fell(clear_n) |=> !clear_n[*8]) else $error("clear len");
    idle_a: assert property (!busy && $past(!busy) |-> conv_clk && bit_count == 4'h0)
        else $error("idle");
endmodule // dtwsl_host_sva

//--- tb/testbench.sv
// Purpose: self-checking bench for the loader
// Assumes: clear shortened to 20 cycles
// Notes: two converter models share the data line
`timescale 1ns/1ps
module testbench;
    logic clk, sys_rst, word_valid, clear_req;
    logic [0:0] word_sel;
    logic [11:0] word_data;
    wire word_ready, serial_clk, serial_data_in, conv_clk, load_strobe_n, clear_n, limit_converter_select, busy;
    wire [1:0] chip_select_n;
    wire [3:0] bit_count;
    wire [11:0] v0, v1;
    int miscompares, num_checks, pulses, n;
    dtwsl_host #(.CLR_CYCLES(20)) dut_u (.clk(clk), .sys_rst(sys_rst), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data), .word_sel(word_sel), .clear_req(clear_req),
        .serial_clk(serial_clk), .serial_data_in(serial_data_in), .conv_clk(conv_clk),
        .load_strobe_n(load_strobe_n), .clear_n(clear_n), .chip_select_n(chip_select_n),
        .limit_converter_select(limit_converter_select), .bit_count(bit_count), .busy(busy));
    dtwsl_conv_model u0 (.conv_clk(conv_clk), .serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n),
        .clear_n(clear_n), .select_n(chip_select_n[0]), .value(v0));
    dtwsl_conv_model u1 (.conv_clk(conv_clk), .serial_data_in(serial_data_in), .load_strobe_n(load_strobe_n),
        .clear_n(clear_n), .select_n(chip_select_n[1]), .value(v1));
    always @(posedge serial_clk) pulses++;
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input bit ok, input string m);
        num_checks++;
        if (!ok) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task timeout;
        miscompares++;
        $display("[FAIL] %0t wait expired", $time);
        print_verdict;
    endtask
    task push(input logic [11:0] d, input logic s);
        @(posedge clk);
        word_valid <= 1'b1;
        word_data <= d;
        word_sel <= s;
        for (int i = 0; i < 400; i++) begin
            @(negedge clk);
            if (word_ready === 1'b1) begin
                @(posedge clk);
                word_valid <= 1'b0;
                return;
            end
        end
        timeout;
    endtask
    task wait_idle;
        n = 0;
        for (int i = 0; i < 3000 && n < 12; i++) begin
            @(negedge clk);
            n = (busy === 1'b0 && clear_n === 1'b1) ? n + 1 : 0;
        end
        if (n < 12) timeout;
    endtask
    task t_power;
        chk(clear_n === 1'b0 && v0 === 12'h000 && v1 === 12'h000, "power clear");
        n = 0;
        while (clear_n !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(n >= 20 && n < 200, "clear length");
        $display("power test done");
    endtask
    task t_one;
        pulses = 0;
        push(12'hA5C, 1'b0);
        wait_idle;
        chk(v0 === 12'hA5C && v1 === 12'h000, "single word");
        chk(pulses == 13 && conv_clk === 1'b1 && bit_count === 4'h0, "stop state");
        $display("single test done");
    endtask
    task t_burst;
        pulses = 0;
        push(12'h123, 1'b0);
        push(12'hFFF, 1'b1);
        push(12'h800, 1'b0);
        push(12'h001, 1'b1);
        wait_idle;
        chk(v0 === 12'h800 && v1 === 12'h001, "burst words");
        chk(pulses == 52 && chip_select_n === 2'h3, "burst pulses");
        chk(limit_converter_select === 1'b1, "limit select");
        $display("burst test done");
    endtask
    task t_clear;
        @(posedge clk);
        clear_req <= 1'b1;
        @(posedge clk);
        clear_req <= 1'b0;
        repeat (3) @(negedge clk);
        chk(clear_n === 1'b0 && v0 === 12'h000 && v1 === 12'h000, "clear request");
        push(12'h7FF, 1'b1);
        wait_idle;
        chk(v1 === 12'h7FF && v0 === 12'h000, "word after clear");
        $display("clear test done");
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        sys_rst = 1'b1;
        word_valid = 1'b0;
        clear_req = 1'b0;
        word_sel = 1'b0;
        word_data = 12'h000;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        t_power;
        t_one;
        t_burst;
        t_clear;
        print_verdict;
    end
endmodule // testbench
bind dtwsl_host dtwsl_host_sva #(.NCONV(NCONV), .SELW(SELW)) chk_u (.clk(clk), .sys_rst(sys_rst),
    .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data), .word_sel(word_sel),
    .clear_req(clear_req), .serial_clk(serial_clk), .serial_data_in(serial_data_in), .conv_clk(conv_clk),
    .load_strobe_n(load_strobe_n), .clear_n(clear_n), .chip_select_n(chip_select_n),
    .limit_converter_select(limit_converter_select), .bit_count(bit_count), .busy(busy));
